// ---- rtl/port_b_handshake_aux_control.sv ----
// Port B control lines, flag logic and auxiliary control register.
// Assumes a synchronous register bus strobed one cycle per access.
module port_b_handshake_aux_control
    import port_ctl_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       busSelect,
    input  wire logic       busWrite,
    input  wire logic [3:0] busAddr,
    input  wire logic [7:0] busWData,
    output logic      [7:0] busRData,
    input  wire logic       porta_line1_flag,
    input  wire logic [7:0] portaPins,
    input  wire logic [7:0] portbPins,
    input  wire logic       portb_line1_in,
    output logic            portb_line1_out,
    output logic            portb_line1_oe,
    input  wire logic       portb_line2_in,
    output logic            portb_line2_out,
    output logic            portb_line2_oe,
    input  wire logic       shiftClockOut,
    output logic            portb_line1_flag,
    output logic            portb_line2_flag,
    output logic [2:0]      shifterMode,
    output logic            timer_two_count_select,
    output logic            timer_one_freerun_select,
    output logic            timer_one_pin_output_enable
);
    import port_ctl_pkg::*;

    logic       rstMeta, rstN;
    logic [7:0] peripheral_line_control;
    logic [7:0] auxiliary_function_control;
    logic [7:0] portb_output_register;
    logic [7:0] portbDir;
    logic [1:0] l1Sync, l2Sync;
    logic       l1Prev, l2Prev;
    logic [7:0] paMeta, paSync, pbMeta, pbSync;
    logic       paFlagMeta, paFlagSync;
    logic [7:0] paLatch, pbLatch;
    logic       line1Edge, line2Edge, portbAccess, portbWrite, flagWrite;
    logic       shiftOn, shiftOutClk;
    line2_mode_t line2Mode;
    shift_mode_t shiftMode;

    // Reset release
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstN    <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN    <= rstMeta;
        end
    end

    // Pin synchronisers
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            l1Sync     <= 2'h3;
            l2Sync     <= 2'h3;
            l1Prev     <= 1'b1;
            l2Prev     <= 1'b1;
            paMeta     <= 8'h00;
            paSync     <= 8'h00;
            pbMeta     <= 8'h00;
            pbSync     <= 8'h00;
            paFlagMeta <= 1'b0;
            paFlagSync <= 1'b0;
        end else begin
            l1Sync     <= {l1Sync[0], portb_line1_in};
            l2Sync     <= {l2Sync[0], portb_line2_in};
            l1Prev     <= l1Sync[1];
            l2Prev     <= l2Sync[1];
            paMeta     <= portaPins;
            paSync     <= paMeta;
            pbMeta     <= portbPins;
            pbSync     <= pbMeta;
            paFlagMeta <= porta_line1_flag;
            paFlagSync <= paFlagMeta;
        end
    end

    assign line2Mode   = line2_mode_t'(peripheral_line_control[PCR_MODE_B2HI:PCR_MODE_B2LO]);
    assign shiftMode   = shift_mode_t'(auxiliary_function_control[AUX_SHIFT_HI:AUX_SHIFT_LO]);
    assign shiftOn     = (shiftMode != SHIFT_OFF);
    assign shiftOutClk = shiftOn && (shiftMode != SHIFT_IN_EXT) && (shiftMode != SHIFT_OUT_EXT);
    // Edge seen on pin level, whether driven here or from outside
    assign line1Edge = peripheral_line_control[PCR_EDGE_B1] ? (l1Sync[1] && !l1Prev)
                                                            : (!l1Sync[1] && l1Prev);
    assign line2Edge = line2Mode[1] ? (l2Sync[1] && !l2Prev) : (!l2Sync[1] && l2Prev);
    assign portbAccess = busSelect && (busAddr == ADDR_PORTB_OUT);
    assign portbWrite  = portbAccess && busWrite;
    assign flagWrite   = busSelect && busWrite && (busAddr == ADDR_FLAGS);

    // Control registers
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            peripheral_line_control    <= PERIPH_RESET;
            auxiliary_function_control <= AUX_RESET;
            portb_output_register      <= 8'h00;
            portbDir                   <= 8'h00;
        end else if (busSelect && busWrite) begin
            case (busAddr)
                ADDR_PERIPH_CTL: peripheral_line_control    <= busWData;
                ADDR_AUX_CTL:    auxiliary_function_control <= busWData;
                ADDR_PORTB_OUT:  portb_output_register      <= busWData;
                ADDR_PORTB_DIR:  portbDir                   <= busWData;
                default: ;
            endcase
        end
    end

    // Mode fields to timers and shifter
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            shifterMode                 <= 3'h0;
            timer_two_count_select      <= 1'b0;
            timer_one_freerun_select    <= 1'b0;
            timer_one_pin_output_enable <= 1'b0;
        end else begin
            shifterMode                 <= shiftMode;
            timer_two_count_select      <= auxiliary_function_control[AUX_T2_COUNT];
            timer_one_freerun_select    <= auxiliary_function_control[AUX_T1_FREE];
            timer_one_pin_output_enable <= auxiliary_function_control[AUX_T1_PIN];
        end
    end

    // Line-1 flag: set wins over clear
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            portb_line1_flag <= 1'b0;
        end else if (line1Edge) begin
            portb_line1_flag <= 1'b1;
        end else if (portbAccess || (flagWrite && busWData[FLAG_B1])) begin
            portb_line1_flag <= 1'b0;
        end
    end

    // Line-2 flag
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            portb_line2_flag <= 1'b0;
        end else if (!line2Mode[2] && !shiftOn && line2Edge) begin
            portb_line2_flag <= 1'b1;
        end else if (portbAccess && !line2Mode[2] && !line2Mode[0]) begin
            portb_line2_flag <= 1'b0;
        end else if (flagWrite && busWData[FLAG_B2]) begin
            portb_line2_flag <= 1'b0;
        end
    end

    // Line-1 pin drive in internally clocked shift modes (not SHIFT_IN_EXT or SHIFT_OUT_EXT)
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            portb_line1_oe  <= 1'b0;
            portb_line1_out <= 1'b1;
        end else begin
            portb_line1_oe  <= shiftOutClk;
            portb_line1_out <= shiftOutClk ? shiftClockOut : 1'b1;
        end
    end

    // Line-2 output modes
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            portb_line2_oe  <= 1'b0;
            portb_line2_out <= 1'b1;
        end else begin
            portb_line2_oe <= line2Mode[2] && !shiftOn;
            case (line2Mode)
                LINE2_HANDSHAKE: begin
                    if (portbWrite) begin
                        portb_line2_out <= 1'b0;
                    end else if (line1Edge) begin
                        portb_line2_out <= 1'b1;
                    end
                end
                LINE2_PULSE: portb_line2_out <= !portbWrite;
                LINE2_LOW:   portb_line2_out <= 1'b0;
                LINE2_HIGH:  portb_line2_out <= 1'b1;
                default:     portb_line2_out <= 1'b1;
            endcase
        end
    end

    port_latch latchA (
        .clk     (ref_clk),
        .rstN    (rstN),
        .enable  (auxiliary_function_control[AUX_LATCH_A]),
        .flagSet (paFlagSync),
        .source  (paSync),
        .latched (paLatch)
    );

    port_latch latchB (
        .clk     (ref_clk),
        .rstN    (rstN),
        .enable  (auxiliary_function_control[AUX_LATCH_B]),
        .flagSet (portb_line1_flag),
        .source  ((pbSync & ~portbDir) | (portb_output_register & portbDir)),
        .latched (pbLatch)
    );

    // Read data
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            busRData <= 8'h00;
        end else if (busSelect && !busWrite) begin
            case (busAddr)
                ADDR_PORTB_OUT:  busRData <= pbLatch;
                ADDR_PORTA_OUT:  busRData <= paLatch;
                ADDR_PORTB_DIR:  busRData <= portbDir;
                ADDR_FLAGS:      busRData <= {3'h0, portb_line1_flag, portb_line2_flag, 3'h0};
                ADDR_PERIPH_CTL: busRData <= peripheral_line_control;
                ADDR_AUX_CTL:    busRData <= auxiliary_function_control;
                default:         busRData <= 8'h00;
            endcase
        end
    end

    line1_flag_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        line1Edge |=> portb_line1_flag) else $error("line1 flag not set");
    line1_clear_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        portbAccess && !line1Edge |=> !portb_line1_flag) else $error("line1 not cleared");
    shift_pin_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        shiftOutClk |=> portb_line1_oe) else $error("shift clock not driven");
    shift_idle_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        !shiftOutClk |=> !portb_line1_oe && portb_line1_out)
        else $error("line1 driven outside shift");
    shift_edge_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        shiftOn && line1Edge |=> portb_line1_flag)
        else $error("line1 flag lost in shift");
    line2_drive_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        line2Mode[2] && !shiftOn |=> portb_line2_oe)
        else $error("line2 output not driven");
    line2_in_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        !line2Mode[2] |=> !portb_line2_oe)
        else $error("line2 input driven");
    line2_set_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        !line2Mode[2] && !shiftOn && line2Edge |=> portb_line2_flag)
        else $error("line2 flag not set");
    keep_flag_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        portbAccess && line2Mode == LINE2_IND_FALL && portb_line2_flag && !flagWrite
        |=> portb_line2_flag) else $error("independent flag cleared");
    hand_low_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        line2Mode == LINE2_HANDSHAKE && portbWrite |=> !portb_line2_out)
        else $error("handshake not low");
    hand_rise_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        line2Mode == LINE2_HANDSHAKE && !portbWrite && line1Edge |=> portb_line2_out)
        else $error("handshake not released");
    pulse_low_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        line2Mode == LINE2_PULSE && portbWrite |=> !portb_line2_out)
        else $error("pulse missing");
    pulse_one_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        line2Mode == LINE2_PULSE && portbWrite ##1 line2Mode == LINE2_PULSE && !portbWrite
        |=> portb_line2_out) else $error("pulse too long");
    manual_low_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        line2Mode == LINE2_LOW |=> !portb_line2_out) else $error("manual low lost");
    manual_high_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        line2Mode == LINE2_HIGH |=> portb_line2_out) else $error("manual high lost");
    aux_map_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        1'b1 |=> shifterMode == $past(auxiliary_function_control[AUX_SHIFT_HI:AUX_SHIFT_LO]))
        else $error("shift mode field wrong");
    timer_fields_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        1'b1 |=> {timer_one_pin_output_enable, timer_one_freerun_select, timer_two_count_select}
            == $past(auxiliary_function_control[AUX_T1_PIN:AUX_T2_COUNT]))
        else $error("timer fields wrong");
    pa_follow_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        !auxiliary_function_control[AUX_LATCH_A] |=> paLatch == $past(paSync))
        else $error("port A latch not transparent");
    pa_read_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        busSelect && !busWrite && busAddr == ADDR_PORTA_OUT |=> busRData == $past(paLatch))
        else $error("port A read not from latch");
    flag_write_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        flagWrite && busWData[FLAG_B2] && !line2Edge |=> !portb_line2_flag)
        else $error("flag write no clear");

    // Cover points
    hand_cover: cover property (@(posedge ref_clk) disable iff (!rstN)
        line2Mode == LINE2_HANDSHAKE && portbWrite ##[1:20] portb_line2_out);
    pulse_cover: cover property (@(posedge ref_clk) disable iff (!rstN)
        line2Mode == LINE2_PULSE && portbWrite);
    edge_cover: cover property (@(posedge ref_clk) disable iff (!rstN)
        line1Edge && portbAccess);
    shift_cover: cover property (@(posedge ref_clk) disable iff (!rstN)
        shiftOutClk && line1Edge);
    line2_cover: cover property (@(posedge ref_clk) disable iff (!rstN)
        !line2Mode[2] && !shiftOn && line2Edge);
endmodule // port_b_handshake_aux_control

// ---- rtl/port_ctl_pkg.sv ----
// Constants for the port B handshake and auxiliary control block.
// Assumes a single 250 MHz clock domain and 8-bit register bus.
package port_ctl_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam logic [3:0] ADDR_PORTB_OUT  = 4'h0;
    localparam logic [3:0] ADDR_PORTA_OUT  = 4'h1;
    localparam logic [3:0] ADDR_PORTB_DIR  = 4'h2;
    localparam logic [3:0] ADDR_FLAGS      = 4'hD;
    localparam logic [3:0] ADDR_PERIPH_CTL = 4'hC;
    localparam logic [3:0] ADDR_AUX_CTL    = 4'hB;
    localparam logic [7:0] PERIPH_RESET    = 8'h00;
    localparam logic [7:0] AUX_RESET       = 8'h00;
    localparam int PCR_EDGE_B1   = 4;
    localparam int PCR_MODE_B2LO = 5;
    localparam int PCR_MODE_B2HI = 7;
    localparam int AUX_LATCH_A   = 0;
    localparam int AUX_LATCH_B   = 1;
    localparam int AUX_SHIFT_LO  = 2;
    localparam int AUX_SHIFT_HI  = 4;
    localparam int AUX_T2_COUNT  = 5;
    localparam int AUX_T1_FREE   = 6;
    localparam int AUX_T1_PIN    = 7;
    localparam int FLAG_B2 = 3;
    localparam int FLAG_B1 = 4;
    typedef enum logic [2:0] {
        LINE2_IN_FALL, LINE2_IND_FALL, LINE2_IN_RISE, LINE2_IND_RISE,
        LINE2_HANDSHAKE, LINE2_PULSE, LINE2_LOW, LINE2_HIGH
    } line2_mode_t;
    typedef enum logic [2:0] {
        SHIFT_OFF, SHIFT_IN_T2, SHIFT_IN_SYS, SHIFT_IN_EXT,
        SHIFT_FREE_T2, SHIFT_OUT_T2, SHIFT_OUT_SYS, SHIFT_OUT_EXT
    } shift_mode_t;
endpackage

// ---- rtl/port_latch.sv ----
// Eight-bit input latch, transparent when disabled, held while the flag is set.
// Assumes pin data is already synchronised to clk.
module port_latch (
    input  wire logic       clk,
    input  wire logic       rstN,
    input  wire logic       enable,
    input  wire logic       flagSet,
    input  wire logic [7:0] source,
    output logic      [7:0] latched
);
    logic heldPrev;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            heldPrev <= 1'b0;
        end else begin
            heldPrev <= flagSet;
        end
    end
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            latched <= 8'h00;
        end else if (!enable || !heldPrev) begin
            latched <= source;
        end
    end

    hold_latch_a: assert property (@(posedge clk) disable iff (!rstN)
        enable && heldPrev |=> $stable(latched)) else $error("latch not held");
endmodule // port_latch

// ---- dv/periph_model.sv ----
// Peripheral model for the port B control lines and both port pin groups.
// Assumes the bench resolves the shared control pins from the design's enables.
module periph_model (
    input  wire logic       clk,
    output logic            line1,
    output logic            line2,
    output logic      [7:0] pinsA,
    output logic      [7:0] pinsB
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        line1 = 1'b1;
        line2 = 1'b1;
        pinsA = 8'h00;
        pinsB = 8'h00;
    end
    // Move one control line, then allow for the input synchroniser
    task automatic setLine(input bit second, input logic v);
        @(posedge clk);
        if (second) line2 <= v;
        else line1 <= v;
        repeat (6) @(posedge clk);
    endtask
    task automatic setPins(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk);
        pinsA <= a;
        pinsB <= b;
        repeat (4) @(posedge clk);
    endtask
endmodule // periph_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the port B handshake and auxiliary control block.
// Assumes one 250 MHz clock and the register map of port_ctl_pkg.
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import port_ctl_pkg::*;
    logic       ref_clk = 1'b0, nrst = 1'b0, busSelect = 1'b0, busWrite = 1'b0, aFlag = 1'b0;
    logic [3:0] busAddr = 4'h0;
    logic [7:0] busWData = 8'h00, busRData, pinsA, pinsB, r, s, expVal;
    logic       l1Drv, l2Drv, l1Out, l1Oe, l2Out, l2Oe, l1Flag, l2Flag, rdPend = 1'b0;
    logic       t2c, t1f, t1p, shClk = 1'b1;
    logic [2:0] shMode;
    logic [7:0] expQ[$];
    int         err_count = 0, cmp_count = 0;
    wire logic  l1In = l1Oe ? l1Out : l1Drv;
    wire logic  l2In = l2Oe ? l2Out : l2Drv;
    port_b_handshake_aux_control u_port_b_handshake_aux_control (.ref_clk(ref_clk),
        .nrst(nrst), .busSelect(busSelect), .busWrite(busWrite), .busAddr(busAddr),
        .busWData(busWData), .busRData(busRData), .porta_line1_flag(aFlag),
        .portaPins(pinsA), .portbPins(pinsB), .portb_line1_in(l1In),
        .portb_line1_out(l1Out), .portb_line1_oe(l1Oe), .portb_line2_in(l2In),
        .portb_line2_out(l2Out), .portb_line2_oe(l2Oe), .shiftClockOut(shClk),
        .portb_line1_flag(l1Flag), .portb_line2_flag(l2Flag), .shifterMode(shMode),
        .timer_two_count_select(t2c), .timer_one_freerun_select(t1f),
        .timer_one_pin_output_enable(t1p));
    periph_model u_periph_model (.clk(ref_clk), .line1(l1Drv), .line2(l2Drv),
        .pinsA(pinsA), .pinsB(pinsB));
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        busSelect <= 1'b1;
        busWrite <= w;
        busAddr <= a;
        busWData <= d;
        @(posedge ref_clk);
        busSelect <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        expQ.push_back(e);
        acc(1'b0, a, 8'h00);
    endtask
    always @(posedge ref_clk) begin
        rdPend <= busSelect && !busWrite;
        if (rdPend) begin
            expVal = expQ.pop_front();
            `CHK(busRData, expVal)
        end
    end
    task automatic final_report();
        if (err_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        final_report();
    end
    initial begin
        void'($urandom(32'h50d5));
        cyc(4);
        nrst <= 1'b1;
        cyc(3);
        rd(ADDR_AUX_CTL, AUX_RESET);
        rd(ADDR_PERIPH_CTL, PERIPH_RESET);
        rd(4'h5, 8'h00);
        `CHK(l2Out, 1'b1)
        for (int m = 0; m < 8; m++) begin
            r = 8'($urandom);
            acc(1'b1, ADDR_AUX_CTL, {r[7:5], m[2:0], 2'b00});
            rd(ADDR_AUX_CTL, {r[7:5], m[2:0], 2'b00});
            `CHK({t1p, t1f, t2c, shMode}, {r[7:5], m[2:0]})
            `CHK(l1Oe, m != 0 && m != 3 && m != 7)
        end
        for (int k = 0; k < 2; k++) begin
            acc(1'b1, ADDR_AUX_CTL, {3'b000, k ? 3'd3 : 3'd0, 2'b00});
            acc(1'b1, ADDR_PERIPH_CTL, {3'b001, k[0], 4'h0});
            u_periph_model.setLine(1'b0, !k[0]);
            acc(1'b1, ADDR_FLAGS, 8'h18);
            u_periph_model.setLine(1'b0, k[0]);
            rd(ADDR_FLAGS, 8'h10);
            acc(1'b1, ADDR_PORTB_OUT, 8'h00);
            rd(ADDR_FLAGS, 8'h00);
        end
        acc(1'b1, ADDR_AUX_CTL, 8'h00);
        for (int md = 0; md < 4; md++) begin
            acc(1'b1, ADDR_PERIPH_CTL, {md[2:0], 5'h00});
            u_periph_model.setLine(1'b1, !md[1]);
            acc(1'b1, ADDR_FLAGS, 8'h18);
            u_periph_model.setLine(1'b1, md[1]);
            rd(ADDR_FLAGS, 8'h08);
            acc(1'b1, ADDR_PORTB_OUT, 8'h5A);
            rd(ADDR_FLAGS, {4'h0, md[0], 3'h0});
            acc(1'b1, ADDR_FLAGS, 8'h08);
            rd(ADDR_FLAGS, 8'h00);
        end
        acc(1'b1, ADDR_PERIPH_CTL, 8'h80);
        acc(1'b1, ADDR_PORTB_OUT, 8'hA5);
        cyc(8);
        `CHK(l2Out, 1'b0)
        u_periph_model.setLine(1'b0, 1'b0);
        `CHK(l2Out, 1'b1)
        acc(1'b1, ADDR_PERIPH_CTL, 8'hA0);
        busSelect <= 1'b1;
        busAddr <= ADDR_PORTB_OUT;
        @(posedge ref_clk);
        busSelect <= 1'b0;
        @(negedge ref_clk);
        `CHK(l2Out, 1'b0)
        @(negedge ref_clk);
        `CHK(l2Out, 1'b1)
        @(posedge ref_clk);
        for (int md = 6; md < 8; md++) begin
            acc(1'b1, ADDR_PERIPH_CTL, {md[2:0], 5'h00});
            cyc(1);
            `CHK({l2Oe, l2Out}, {1'b1, md[0]})
        end
        r = 8'($urandom);
        s = 8'($urandom);
        u_periph_model.setPins(r, s);
        rd(ADDR_PORTA_OUT, r);
        acc(1'b1, ADDR_AUX_CTL, 8'h01);
        aFlag <= 1'b1;
        cyc(4);
        u_periph_model.setPins(~r, s);
        acc(1'b1, ADDR_PORTA_OUT, ~r);
        rd(ADDR_PORTA_OUT, r);
        aFlag <= 1'b0;
        acc(1'b1, ADDR_PERIPH_CTL, 8'h00);
        acc(1'b1, ADDR_PORTB_DIR, 8'hF0);
        acc(1'b1, ADDR_PORTB_OUT, r);
        acc(1'b1, ADDR_AUX_CTL, 8'h02);
        u_periph_model.setLine(1'b0, 1'b1);
        u_periph_model.setLine(1'b0, 1'b0);
        u_periph_model.setPins(r, ~s);
        rd(ADDR_PORTB_OUT, (r & 8'hF0) | (s & 8'h0F));
        rd(ADDR_FLAGS, 8'h00);
        acc(1'b1, ADDR_AUX_CTL, 8'h08);
        shClk <= 1'b0;
        cyc(6);
        rd(ADDR_FLAGS, 8'h10);
        cyc(4);
        final_report();
    end
endmodule // tb_top
